/* rtl/msl_map.vh */
// Purpose: Constants for the monitor-mode serial loader.
// Assumes: 10 MHz ref_clk, one 8N1 character format on a wired-OR pin.
// Notes: Rule summary follows.
`ifndef MSL_MAP_VH
`define MSL_MAP_VH
`define MSL_OP_READ 8'h4a
`define MSL_OP_INDEXED_READ_CMD 8'h1a
`define MSL_OP_STACK_POINTER_READ_CMD 8'h0c
`define MSL_SEC_FIRST 16'hfff6
`define MSL_SEC_COUNT 4'h8
`define MSL_BREAK_BITS 4'ha
`define MSL_VEC_RESET 16'hfefe
`define MSL_VEC_SWI 16'hfefc
`define MSL_VEC_USER_RESET 16'hfffe
`define MSL_VEC_USER_SWI 16'hfffc
`define MSL_CLK_HZ 10000000
`define MSL_BASE_BAUD 4800
`endif

/* rtl/msl_monitor_loader.v */
// Purpose: Monitor-mode command interpreter on a single serial pin.
// Assumes: Pin input synchronous to ref_clk; memory answers in one cycle.
// Notes: Bit time derives from 4800 baud times a clock-selected multiplier.
`include "msl_map.vh"
module msl_monitor_loader #(
  parameter CLK_HZ = `MSL_CLK_HZ,
  parameter BASE_BAUD = `MSL_BASE_BAUD
) (
  input wire ref_clk,
  input wire rst_n,
  input wire powerOnReset,
  input wire testHighVoltageIrq,
  input wire testHighVoltageRst,
  input wire entryStrapA,
  input wire entryStrapB,
  input wire clockDividerStrap,
  input wire softwareInterruptInstruction,
  input wire pllSelected,
  input wire [3:0] pllMultiplierField,
  input wire monitorSerialPinIn,
  output reg monitorSerialPinOut,
  output reg monitorSerialPinOe,
  output reg [15:0] memAddr,
  output reg memRead,
  input wire [7:0] memData,
  input wire [15:0] stackPointer,
  output reg monitorMode,
  output reg oscBypass,
  output wire [15:0] resetVector,
  output wire [15:0] swiVector,
  output wire watchdogEnable,
  output reg securityBypassed,
  output reg flashBlocked,
  output reg illegalAddressLoop
);
  // Bit period in clocks; multiplier scales speed
  function [15:0] bitClocks;
    input [3:0] mult;
    reg [31:0] q;
    begin
      q = CLK_HZ / (BASE_BAUD * (mult == 4'h0 ? 1 : mult));
      bitClocks = q[15:0];
    end
  endfunction
  // Receive path
  localparam RX_IDLE = 2'd0, RX_BITS = 2'd1, RX_STOP = 2'd2, RX_HOLD = 2'd3;
  // Transmit path
  localparam TX_IDLE = 3'd0, TX_GAP = 3'd1, TX_START = 3'd2, TX_BITS = 3'd3,
    TX_STOP = 3'd4, TX_BRK = 3'd5;
  // Command engine
  localparam C_SEC = 3'd0, C_BRK = 3'd1, C_OP = 3'd2, C_AH = 3'd3,
    C_AL = 3'd4, C_RD = 3'd5;
  wire monitorEntry = testHighVoltageIrq & entryStrapA & ~entryStrapB & monitorSerialPinIn;
  reg [3:0] baudMult; // Latched at entry
  reg [15:0] rxCnt;
  reg [1:0] rxState;
  reg [3:0] rxBit;
  reg [7:0] rxShift;
  reg rxAllZero;
  reg rxValid; // One-cycle byte strobe
  reg rxBreak; // One-cycle break strobe
  reg [7:0] rxByte;
  // Two-entry buffer toward the transmitter
  reg [8:0] bufMem [0:1]; // Bit 8 marks a break
  reg bufWr, bufRd;
  reg [1:0] bufCount;
  wire bufReady = (bufCount != 2'd2);
  wire bufValid = (bufCount != 2'd0);
  reg pushValid;
  reg [8:0] pushData;
  reg [2:0] txState;
  reg [15:0] txCnt;
  reg [3:0] txBit;
  reg [8:0] txShift;
  reg [2:0] cmdState;
  reg [3:0] secIdx;
  reg secOk;
  reg [7:0] opcode;
  reg [1:0] remain;
  reg rdPending;
  reg resetSeen; // High through reset and its first cycle after
  wire secLast = (cmdState == C_SEC) && rxValid && (secIdx == `MSL_SEC_COUNT - 4'h1);
  wire secMatch = secOk && (rxByte == memData);
  wire [15:0] bitLen = bitClocks(baudMult);
  assign resetVector = monitorMode ? `MSL_VEC_RESET : `MSL_VEC_USER_RESET;
  assign swiVector = monitorMode ? `MSL_VEC_SWI : `MSL_VEC_USER_SWI;
  assign watchdogEnable = ~(monitorMode & (testHighVoltageIrq | testHighVoltageRst));
  // Entry and clock selection latched after reset release
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      monitorMode <= 1'b0;
      oscBypass <= 1'b0;
      baudMult <= 4'h1;
    end else if (!monitorMode && (monitorEntry || softwareInterruptInstruction)) begin
      monitorMode <= 1'b1;
      oscBypass <= ~clockDividerStrap;
      // Strap low doubles the rate; PLL uses its multiplier
      baudMult <= pllSelected ? pllMultiplierField : (clockDividerStrap ? 4'h1 : 4'h2);
    end
  end
  // Receiver: start, eight bits LSB first, stop; nine lows after start is a break
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxCnt <= 16'h0000;
      rxBit <= 4'h0;
      rxShift <= 8'h00;
      rxAllZero <= 1'b0;
      rxValid <= 1'b0;
      rxBreak <= 1'b0;
      rxByte <= 8'h00;
    end else begin
      rxValid <= 1'b0;
      rxBreak <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          // Ignore our own transmission on the shared line
          if (monitorMode && !monitorSerialPinIn && txState == TX_IDLE) begin
            rxState <= RX_BITS;
            rxCnt <= {1'b0, bitLen[15:1]} + bitLen; // Centre of bit 0
            rxBit <= 4'h0;
            rxAllZero <= 1'b1;
          end
        end
        RX_BITS: begin
          if (rxCnt == 16'h0000) begin
            rxShift <= {monitorSerialPinIn, rxShift[7:1]};
            rxAllZero <= rxAllZero & ~monitorSerialPinIn;
            rxCnt <= bitLen - 16'h0001;
            rxBit <= rxBit + 4'h1;
            if (rxBit == 4'h7) rxState <= RX_STOP;
          end else begin
            rxCnt <= rxCnt - 16'h0001;
          end
        end
        RX_STOP: begin
          if (rxCnt == 16'h0000) begin
            if (!monitorSerialPinIn && rxAllZero) begin
              rxBreak <= 1'b1;
            end else if (monitorSerialPinIn) begin
              rxValid <= 1'b1;
              rxByte <= rxShift;
            end
            rxState <= monitorSerialPinIn ? RX_IDLE : RX_HOLD;
          end else begin
            rxCnt <= rxCnt - 16'h0001;
          end
        end
        // Break or bad stop held low: a break strobes once, a bad stop not at all; then wait for line release
        RX_HOLD: if (monitorSerialPinIn) rxState <= RX_IDLE;
        default: rxState <= RX_IDLE;
      endcase
    end
  end
  wire [7:0] spByte = remain[0] ? stackPointer[15:8] : stackPointer[7:0];
  // Buffer push selection: echo first, then results
  always @* begin
    pushValid = 1'b0;
    pushData = 9'h000;
    if (rxBreak) begin
      pushValid = 1'b1;
      pushData = 9'h100;
    end else if (rxValid) begin
      pushValid = 1'b1;
      pushData = {1'b0, rxByte};
    end else if (cmdState == C_BRK && !bufValid && txState == TX_IDLE) begin
      pushValid = 1'b1;
      pushData = 9'h100;
    end else if (rdPending) begin
      pushValid = 1'b1;
      pushData = {1'b0, (opcode == `MSL_OP_STACK_POINTER_READ_CMD) ? spByte : memData};
    end
  end
  // Two-entry buffer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufWr <= 1'b0;
      bufRd <= 1'b0;
      bufCount <= 2'd0;
      bufMem[0] <= 9'h000;
      bufMem[1] <= 9'h000;
    end else begin
      if (pushValid && bufReady) begin
        bufMem[bufWr] <= pushData;
        bufWr <= ~bufWr;
      end
      if (txState == TX_IDLE && bufValid) bufRd <= ~bufRd;
      bufCount <= bufCount + {1'b0, pushValid && bufReady}
        - {1'b0, txState == TX_IDLE && bufValid};
    end
  end
  // Transmitter: drives low only; releases the line for a one
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      txCnt <= 16'h0000;
      txBit <= 4'h0;
      txShift <= 9'h000;
      monitorSerialPinOut <= 1'b0;
      monitorSerialPinOe <= 1'b0;
    end else begin
      monitorSerialPinOut <= 1'b0;
      case (txState)
        TX_IDLE: begin
          monitorSerialPinOe <= 1'b0;
          if (bufValid) begin
            txShift <= bufMem[bufRd];
            txCnt <= bufLenGap(bufMem[bufRd][8]);
            txState <= bufMem[bufRd][8] ? TX_GAP : TX_START;
          end
        end
        TX_GAP: begin
          // Line held released (high) two bit times before a break
          monitorSerialPinOe <= 1'b0;
          if (txCnt == 16'h0000) begin
            txState <= TX_BRK;
            txBit <= `MSL_BREAK_BITS;
            txCnt <= bitLen - 16'h0001;
          end else txCnt <= txCnt - 16'h0001;
        end
        TX_BRK: begin
          monitorSerialPinOe <= 1'b1;
          if (txCnt == 16'h0000) begin
            txCnt <= bitLen - 16'h0001;
            txBit <= txBit - 4'h1;
            if (txBit == 4'h1) txState <= TX_STOP;
          end else txCnt <= txCnt - 16'h0001;
        end
        TX_START: begin
          monitorSerialPinOe <= 1'b1;
          if (txCnt == 16'h0000) begin
            txState <= TX_BITS;
            txBit <= 4'h0;
            txCnt <= bitLen - 16'h0001;
          end else txCnt <= txCnt - 16'h0001;
        end
        TX_BITS: begin
          monitorSerialPinOe <= ~txShift[0];
          if (txCnt == 16'h0000) begin
            txShift <= {1'b0, txShift[8:1]};
            txCnt <= bitLen - 16'h0001;
            txBit <= txBit + 4'h1;
            if (txBit == 4'h7) txState <= TX_STOP;
          end else txCnt <= txCnt - 16'h0001;
        end
        TX_STOP: begin
          monitorSerialPinOe <= 1'b0;
          if (txCnt == 16'h0000) txState <= TX_IDLE;
          else txCnt <= txCnt - 16'h0001;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end
  // Gap before a break is two bit times; a byte starts straight away
  function [15:0] bufLenGap;
    input isBrk;
    begin
      bufLenGap = isBrk ? (bitLen + bitLen - 16'h0001) : (bitLen - 16'h0001);
    end
  endfunction
  // Security outcome survives rst_n; power-on reset clears it and must open the run
  always @(posedge ref_clk) begin
    if (powerOnReset) begin
      securityBypassed <= 1'b0;
      flashBlocked <= 1'b0;
      illegalAddressLoop <= 1'b0;
    end else begin
      if (secLast && secMatch && !flashBlocked) securityBypassed <= 1'b1;
      if (secLast && !secMatch && !securityBypassed) flashBlocked <= 1'b1;
      if (resetSeen && flashBlocked) illegalAddressLoop <= 1'b1;
    end
  end
  // Command engine: security phase, break, then commands
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdState <= C_SEC;
      secIdx <= 4'h0;
      secOk <= 1'b1;
      opcode <= 8'h00;
      memAddr <= 16'h0000;
      memRead <= 1'b0;
      remain <= 2'd0;
      rdPending <= 1'b0;
      resetSeen <= 1'b1;
    end else begin
      memRead <= 1'b0;
      resetSeen <= 1'b0;
      if (rdPending && bufReady && !rxValid && !rxBreak) rdPending <= 1'b0;
      case (cmdState)
        C_SEC: begin
          if (secIdx == 4'h0 && !rxValid) memAddr <= `MSL_SEC_FIRST;
          if (rxValid) begin
            if (rxByte != memData) secOk <= 1'b0;
            memAddr <= memAddr + 16'h0001;
            secIdx <= secIdx + 4'h1;
            if (secIdx == `MSL_SEC_COUNT - 4'h1) cmdState <= C_BRK;
          end
        end
        C_BRK: if (pushData[8] && pushValid && bufReady && !rxValid) cmdState <= C_OP;
        C_OP: begin
          if (rxValid) begin
            opcode <= rxByte;
            if (rxByte == `MSL_OP_READ) cmdState <= C_AH;
            else if (rxByte == `MSL_OP_INDEXED_READ_CMD || rxByte == `MSL_OP_STACK_POINTER_READ_CMD) begin
              cmdState <= C_RD;
              remain <= 2'd2;
            end
          end
        end
        C_AH: if (rxValid) begin
          memAddr[15:8] <= rxByte;
          cmdState <= C_AL;
        end
        C_AL: if (rxValid) begin
          memAddr[7:0] <= rxByte;
          remain <= 2'd1;
          cmdState <= C_RD;
          opcode <= `MSL_OP_READ;
        end
        C_RD: begin
          // Results queue behind the echo already in the buffer
          if (!rdPending && !rxValid) begin
            if (remain != 2'd0 && bufReady) begin
              if (opcode == `MSL_OP_INDEXED_READ_CMD) memAddr <= memAddr + 16'h0001;
              memRead <= (opcode != `MSL_OP_STACK_POINTER_READ_CMD);
              rdPending <= 1'b1;
              remain <= remain - 2'd1;
            end else if (remain == 2'd0) cmdState <= C_OP;
          end
        end
        default: cmdState <= C_OP;
      endcase
    end
  end
endmodule // msl_monitor_loader

/* verification/msl_host_model.sv */
// Purpose: Host computer at the far end of the single-wire link.
// Assumes: Line has a pull-up; the host only pulls low.
// Notes: Device frames are queued as stop level over data.
module msl_host_model #(
  parameter BIT = 10
) (
  input wire ref_clk,
  input wire lineLevel,
  output logic hostOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] rxq[$]; // Frames sent by the device
  logic [8:0] frame; // Frame being gathered
  int i; // Bit index
  initial hostOe = 1'b0;
  // Start, data LSB first, then the stop level; same rate both ways
  task automatic sendFrame(input logic [7:0] data, input logic stopHigh);
    logic [9:0] bits;
    bits = {stopHigh, data, 1'b0};
    for (int k = 0; k < 10; k++) begin
      @(negedge ref_clk);
      hostOe = ~bits[k];
      repeat (BIT - 1) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    hostOe = 1'b0;
  endtask
  // Gather device frames at bit centres
  always begin
    @(posedge ref_clk);
    if (lineLevel === 1'b0 && !hostOe) begin
      repeat (BIT / 2) @(posedge ref_clk);
      for (i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge ref_clk);
        frame[i] = lineLevel;
      end
      rxq.push_back(frame);
      wait (lineLevel === 1'b1);
    end
  end
endmodule // msl_host_model

/* verification/msl_loader_props.sv */
// Purpose: Port assertions for the monitor loader.
// Assumes: Base rate selected, so one bit is CLK_HZ/BASE_BAUD cycles.
// Notes: Bound into every loader instance.
module msl_loader_props #(
  parameter CLK_HZ = 48000,
  parameter BASE_BAUD = 4800
) (
  input wire ref_clk,
  input wire rst_n,
  input wire powerOnReset,
  input wire testHighVoltageIrq,
  input wire testHighVoltageRst,
  input wire monitorSerialPinOut,
  input wire monitorSerialPinOe,
  input wire memRead,
  input wire monitorMode,
  input wire [15:0] resetVector,
  input wire [15:0] swiVector,
  input wire watchdogEnable,
  input wire securityBypassed,
  input wire flashBlocked,
  input wire illegalAddressLoop
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam BIT = CLK_HZ / BASE_BAUD;
  reg [15:0] lowRun; // Cycles of the current pull-low run
  // Measure each pull-low run
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowRun <= 16'h0000;
    end else begin
      lowRun <= monitorSerialPinOe ? lowRun + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pullEnds;
    $fell(monitorSerialPinOe);
  endsequence
  sequence s_irqVoltageGone;
    $fell(testHighVoltageIrq) && monitorMode && !testHighVoltageRst;
  endsequence
  a_whole_bits: assert property (s_pullEnds |-> lowRun % BIT == 0)
    else $error("pull-low run is not whole bits");
  a_only_low: assert property (!monitorSerialPinOut)
    else $error("pin driven high");
  a_reset_page: assert property (resetVector == (monitorMode ? 16'hfefe : 16'hfffe))
    else $error("reset vector page wrong");
  a_swi_page: assert property (swiVector == (monitorMode ? 16'hfefc : 16'hfffc))
    else $error("swi vector page wrong");
  a_wdog_held: assert property (monitorMode && (testHighVoltageIrq || testHighVoltageRst)
    |-> !watchdogEnable)
    else $error("watchdog on under high voltage");
  a_wdog_freed: assert property (s_irqVoltageGone |-> ##[0:2] watchdogEnable)
    else $error("watchdog not enabled");
  a_bypass_held: assert property (securityBypassed && !powerOnReset |=> securityBypassed)
    else $error("bypass lost");
  a_flash_open: assert property (securityBypassed |-> !flashBlocked)
    else $error("flash blocked while bypassed");
  a_read_pulse: assert property (memRead |=> !memRead)
    else $error("read strobe too long");
  a_loop_blocked: assert property (illegalAddressLoop |-> flashBlocked)
    else $error("reset loop without failed security");
endmodule // msl_loader_props
bind msl_monitor_loader msl_loader_props #(.CLK_HZ(CLK_HZ), .BASE_BAUD(BASE_BAUD)) props (
  .ref_clk(ref_clk), .rst_n(rst_n), .testHighVoltageIrq(testHighVoltageIrq),
  .testHighVoltageRst(testHighVoltageRst), .monitorSerialPinOut(monitorSerialPinOut),
  .monitorSerialPinOe(monitorSerialPinOe), .memRead(memRead), .monitorMode(monitorMode),
  .resetVector(resetVector), .swiVector(swiVector), .watchdogEnable(watchdogEnable),
  .securityBypassed(securityBypassed), .flashBlocked(flashBlocked),
  .powerOnReset(powerOnReset), .illegalAddressLoop(illegalAddressLoop));

/* verification/test_monitor_mode_serial_loader.sv */
// Purpose: Self-checking bench for the monitor loader.
// Assumes: CLK_HZ shrunk so one bit is ten cycles.
// Notes: Memory is a random array read combinationally.
module test_monitor_mode_serial_loader;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, powerOnReset = 1'b1; // Clock and resets
  logic testHighVoltageIrq = 1'b1, testHighVoltageRst = 1'b0; // High voltage present
  logic entryStrapA = 1'b1, entryStrapB = 1'b0, clockDividerStrap = 1'b1; // Straps
  logic softwareInterruptInstruction = 1'b0, pllSelected = 1'b0; // Unused software entry path and PLL select
  logic [3:0] pllMultiplierField = 4'h1; // Multiplier
  logic [15:0] stackPointer = 16'h0000, memAddr, resetVector, swiVector, a;
  logic monitorSerialPinOut, monitorSerialPinOe, memRead, monitorMode, oscBypass;
  logic watchdogEnable, securityBypassed, flashBlocked, illegalAddressLoop, hostOe;
  logic [7:0] mem [0:65535]; // Memory behind the loader
  logic [8:0] expQ[$]; // Frames the model expects
  int mismatches = 0, n_tests = 0;
  wire lineLevel = ~(monitorSerialPinOe | hostOe);
  wire [7:0] memData = mem[memAddr];
  always #50 ref_clk = ~ref_clk;
  msl_monitor_loader #(.CLK_HZ(48000), .BASE_BAUD(4800)) msl_monitor_loader_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .powerOnReset(powerOnReset),
    .testHighVoltageIrq(testHighVoltageIrq), .testHighVoltageRst(testHighVoltageRst),
    .entryStrapA(entryStrapA), .entryStrapB(entryStrapB),
    .clockDividerStrap(clockDividerStrap), .pllSelected(pllSelected),
    .softwareInterruptInstruction(softwareInterruptInstruction),
    .pllMultiplierField(pllMultiplierField), .monitorSerialPinIn(lineLevel),
    .monitorSerialPinOut(monitorSerialPinOut), .monitorSerialPinOe(monitorSerialPinOe),
    .memAddr(memAddr), .memRead(memRead), .memData(memData), .stackPointer(stackPointer),
    .monitorMode(monitorMode), .oscBypass(oscBypass), .resetVector(resetVector),
    .swiVector(swiVector), .watchdogEnable(watchdogEnable),
    .securityBypassed(securityBypassed), .flashBlocked(flashBlocked),
    .illegalAddressLoop(illegalAddressLoop));
  msl_host_model #(.BIT(10)) host (.ref_clk(ref_clk), .lineLevel(lineLevel), .hostOe(hostOe));
  // Compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Send a byte, expect its echo ahead of queued results, compare all
  task automatic xfer(input logic [7:0] b, input logic stopHigh);
    int k;
    // Three idle bits let the device finish its stop bit before the next start
    repeat (30) @(negedge ref_clk);
    host.sendFrame(b, stopHigh);
    expQ.push_front({stopHigh, b});
    while (expQ.size() > 0) begin
      k = 0;
      while (host.rxq.size() == 0 && k < 3000) begin
        @(posedge ref_clk);
        k++;
      end
      check(16'(host.rxq.size() > 0 ? host.rxq.pop_front() : 9'h1ff), 16'(expQ.pop_front()));
    end
    @(negedge ref_clk);
  endtask
  // Eight security bytes, the last one followed by the ready break
  task automatic security(input logic [7:0] flip);
    for (int j = 0; j < 8; j++) begin
      if (j == 7) expQ.push_back(9'h000);
      xfer(mem[16'hfff6 + j] ^ flip, 1'b1);
    end
  endtask
  // Pulse rst_n mid-run; por marks the cycle as a power-on reset
  task automatic restart(input logic por);
    powerOnReset = por;
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    powerOnReset = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(16'(monitorMode), 16'h0001);
  endtask
  // Report and end the run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #5000000;
    mismatches++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(67));
    for (int j = 0; j < 65536; j++) mem[j] = 8'($urandom);
    stackPointer = 16'($urandom);
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    powerOnReset = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(16'(monitorMode), 16'h0001);
    check(16'(oscBypass), 16'h0000);
    check(resetVector, 16'hfefe);
    check(swiVector, 16'hfefc);
    check(16'(watchdogEnable), 16'h0000);
    security(8'h00);
    check(16'(securityBypassed), 16'h0001);
    check(16'(flashBlocked), 16'h0000);
    for (int j = 0; j < 2; j++) begin
      a = j ? 16'hfffe : 16'($urandom);
      xfer(8'h4a, 1'b1);
      xfer(a[15:8], 1'b1);
      expQ.push_back({1'b1, mem[a]});
      xfer(a[7:0], 1'b1);
      expQ.push_back({1'b1, mem[a + 16'h0001]});
      expQ.push_back({1'b1, mem[a + 16'h0002]});
      xfer(8'h1a, 1'b1);
    end
    expQ.push_back({1'b1, stackPointer[15:8]});
    expQ.push_back({1'b1, stackPointer[7:0]});
    xfer(8'h0c, 1'b1);
    xfer(8'h00, 1'b0);
    restart(1'b0);
    security(8'($urandom) | 8'h01);
    check(16'(securityBypassed), 16'h0001);
    check(16'(flashBlocked), 16'h0000);
    restart(1'b1);
    for (int j = 0; j < 8; j++) mem[16'hfff6 + j] = 8'h00;
    security(8'h00);
    check(16'(securityBypassed), 16'h0001);
    restart(1'b1);
    security(8'($urandom) | 8'h01);
    check(16'(securityBypassed), 16'h0000);
    check(16'(flashBlocked), 16'h0001);
    check(16'(illegalAddressLoop), 16'h0000);
    restart(1'b0);
    check(16'(illegalAddressLoop), 16'h0001);
    testHighVoltageIrq = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(16'(watchdogEnable), 16'h0001);
    close_out();
  end
endmodule // test_monitor_mode_serial_loader
